// >>> hdl/dsp_mapper.sv
// duty-to-speed profile mapper with ahb-lite configuration registers
//
// What this block does
// (R1) Profile code 10b selects staircase steps
// (R2) Staircase start from zero above low turn-on
// (R3) Staircase below low turn-off: low turn-off level
// (R4) Staircase hold low clamp up to clamp duty
// (R5) Staircase steps at clamp, A, B, C, D, E
// (R6) Staircase hold high clamp up to turn-off
// (R7) Staircase start from zero below high turn-on
// (R8) Staircase above high turn-off: high turn-off level
// (R9) Profile code 11b selects forward-reverse
// (R10) Duty point C splits forward from reverse
// (R11) Forward start from zero above low turn-on
// (R12) Forward below low turn-off: low turn-off level
// (R13) Forward hold low clamp up to clamp duty
// (R14) Forward linear from low clamp to A
// (R15) Forward hold A to B, off above B
// (R16) Reverse above D, level D until E
// (R17) Reverse linear E to clamp, then clamp
// (R18) Reverse start from zero below high turn-on
// (R19) Reverse above high turn-off: high turn-off level
// (R20) Zero duty always stops the motor
// (R21) Direct mode ignores changes under hysteresis
// (R22) Recompute and register on each duty update
// (R23) Turn-on thresholds only apply from zero
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module dsp_mapper
	import dsp_pkg::*;
(
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic [1:0]             hresp,
	output logic [31:0]            hrdata,
	// duty command source
	input  wire logic [DUTY_W-1:0] duty_cmd,
	input  wire logic              duty_valid,
	// speed control loop
	output dsp_ref_t               speed_ref,
	output logic                   speed_valid,
	output logic                   motor_running
);

	// linear interpolation between two duty/level points
	function automatic logic [LVL_W-1:0] lerp(
		input logic [DUTY_W-1:0] d,
		input logic [DUTY_W-1:0] d0,
		input logic [DUTY_W-1:0] d1,
		input logic [LVL_W-1:0]  l0,
		input logic [LVL_W-1:0]  l1
	);
		logic signed [LVL_W+DUTY_W+1:0] num;
		logic signed [LVL_W+DUTY_W+1:0] den;
		logic signed [LVL_W+DUTY_W+1:0] res;
		num = '0;
		den = '0;
		res = '0;
		// degenerate segment: jump straight to the far level
		if (d1 <= d0 || d >= d1) begin
			lerp = l1;
		end else if (d <= d0) begin
			lerp = l0;
		end else begin
			num = ($signed({2'b00, l1}) - $signed({2'b00, l0}))
			      * $signed({2'b00, d - d0});
			den = $signed({{(LVL_W+2){1'b0}}, d1 - d0});
			res = $signed({{(DUTY_W){1'b0}}, 2'b00, l0}) + num / den;
			lerp = res[LVL_W-1:0];
		end
	endfunction

	// absolute difference of two duty values
	function automatic logic [DUTY_W-1:0] duty_dist(
		input logic [DUTY_W-1:0] a,
		input logic [DUTY_W-1:0] b
	);
		duty_dist = (a > b) ? a - b : b - a;
	endfunction

	// writable-bit mask of each register word
	function automatic logic [31:0] wmask(input logic [IDX_W-1:0] ix);
		unique case (ix)
			IX_CTRL:  wmask = MASK_CTRL;
			IX_LDUTY: wmask = MASK_3B;
			IX_HDUTY: wmask = MASK_3B;
			IX_PDUTY: wmask = MASK_4B;
			IX_EDUTY: wmask = MASK_1B;
			IX_LLVL:  wmask = MASK_4B;
			IX_HLVL:  wmask = MASK_4B;
			IX_ABLVL: wmask = MASK_4B;
			IX_CDLVL: wmask = MASK_4B;
			IX_ELVL:  wmask = MASK_1H;
			default:  wmask = MASK_NONE;
		endcase
	endfunction

	// configuration words and bus state
	logic [31:0]      cfg_q [0:NREG-1];
	logic             wr_pend_q;
	logic [IDX_W-1:0] wr_idx_q;
	logic [31:0]      hrdata_q;
	dsp_ref_t         ref_q;
	dsp_ref_t         ref_d;
	logic             valid_q;
	dsp_state_t       state_q;
	dsp_state_t       state_d;
	logic [DUTY_W-1:0] duty_seen_q;
	logic [DUTY_W-1:0] hyst_base_q;
	logic [DUTY_W-1:0] hyst_base_d;

	// address phase decode
	wire              addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ);
	wire              in_map   = (haddr[31:2] < 30'(NREG));
	wire [IDX_W-1:0]  addr_idx = haddr[IDX_W+1:2];
	wire              wr_start = addr_ok && hwrite && in_map;
	wire              rd_start = addr_ok && !hwrite;

	// configuration fields
	wire [1:0]        profile               = cfg_q[IX_CTRL][F_PROF+:2];
	wire [DUTY_W-1:0] duty_hysteresis_width = cfg_q[IX_CTRL][F_HYST+:DUTY_W];
	wire [DUTY_W-1:0] low_turn_on_duty      = cfg_q[IX_LDUTY][F_BYTE0+:DUTY_W];
	wire [DUTY_W-1:0] low_turn_off_duty     = cfg_q[IX_LDUTY][F_BYTE1+:DUTY_W];
	wire [DUTY_W-1:0] low_clamp_duty        = cfg_q[IX_LDUTY][F_BYTE2+:DUTY_W];
	wire [DUTY_W-1:0] high_clamp_duty       = cfg_q[IX_HDUTY][F_BYTE0+:DUTY_W];
	wire [DUTY_W-1:0] high_turn_on_duty     = cfg_q[IX_HDUTY][F_BYTE1+:DUTY_W];
	wire [DUTY_W-1:0] high_turn_off_duty    = cfg_q[IX_HDUTY][F_BYTE2+:DUTY_W];
	wire [DUTY_W-1:0] a_d                   = cfg_q[IX_PDUTY][F_BYTE0+:DUTY_W];
	wire [DUTY_W-1:0] b_d                   = cfg_q[IX_PDUTY][F_BYTE1+:DUTY_W];
	wire [DUTY_W-1:0] c_d                   = cfg_q[IX_PDUTY][F_BYTE2+:DUTY_W];
	wire [DUTY_W-1:0] d_d                   = cfg_q[IX_PDUTY][F_BYTE3+:DUTY_W];
	wire [DUTY_W-1:0] e_d                   = cfg_q[IX_EDUTY][F_BYTE0+:DUTY_W];
	wire [LVL_W-1:0]  low_clamp_level       = cfg_q[IX_LLVL][F_HALF0+:LVL_W];
	wire [LVL_W-1:0]  low_turn_off_level    = cfg_q[IX_LLVL][F_HALF1+:LVL_W];
	wire [LVL_W-1:0]  high_clamp_level      = cfg_q[IX_HLVL][F_HALF0+:LVL_W];
	wire [LVL_W-1:0]  high_turn_off_level   = cfg_q[IX_HLVL][F_HALF1+:LVL_W];
	wire [LVL_W-1:0]  a_l                   = cfg_q[IX_ABLVL][F_HALF0+:LVL_W];
	wire [LVL_W-1:0]  b_l                   = cfg_q[IX_ABLVL][F_HALF1+:LVL_W];
	wire [LVL_W-1:0]  c_l                   = cfg_q[IX_CDLVL][F_HALF0+:LVL_W];
	wire [LVL_W-1:0]  d_l                   = cfg_q[IX_CDLVL][F_HALF1+:LVL_W];
	wire [LVL_W-1:0]  e_l                   = cfg_q[IX_ELVL][F_HALF0+:LVL_W];

	// live status words
	wire [31:0] status_word = {14'h0000, state_q == DSP_RUN, ref_q.reverse, ref_q.level};
	wire [31:0] seen_word   = {24'h00_0000, duty_seen_q};

	// read mux; unmapped words read zero
	wire [31:0] rd_word = !in_map              ? RESET_WORD :
	                      (addr_idx == IX_STATUS) ? status_word :
	                      (addr_idx == IX_DSEEN)  ? seen_word :
	                      (cfg_q[addr_idx] & wmask(addr_idx));

	// bus answers: zero wait state, always okay
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;
	assign hrdata    = hrdata_q;

	// write takes the data phase word; read data loaded at address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= IX_CTRL;
			hrdata_q  <= RESET_WORD;
		end else begin
			wr_pend_q <= wr_start;
			wr_idx_q  <= wr_start ? addr_idx : wr_idx_q;
			hrdata_q  <= rd_start ? rd_word : hrdata_q;
		end
	end

	// configuration store; status words ignore writes via their mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NREG; i++) begin
				cfg_q[i] <= RESET_WORD;
			end
		end else if (wr_pend_q) begin
			cfg_q[wr_idx_q] <= hwdata & wmask(wr_idx_q);
		end
	end

	// off state is tracked from the registered reference
	wire from_zero = (state_q == DSP_OFF); // R23

	// staircase level while running
	wire [LVL_W-1:0] stair_lvl =
		(duty_cmd < low_turn_off_duty)  ? low_turn_off_level :  // R3
		(duty_cmd < low_clamp_duty)     ? low_clamp_level :     // R4
		(duty_cmd < a_d)                ? a_l :                 // R5
		(duty_cmd < b_d)                ? b_l :
		(duty_cmd < c_d)                ? c_l :
		(duty_cmd < d_d)                ? d_l :
		(duty_cmd < e_d)                ? e_l :
		(duty_cmd > high_turn_off_duty) ? high_turn_off_level : // R8
		high_clamp_level;                                       // R6

	// staircase starts only inside both turn-on thresholds
	wire stair_start = (duty_cmd > low_turn_on_duty) &&
	                   (duty_cmd < high_turn_on_duty);  // R2 R7
	wire stair_go    = from_zero ? stair_start : 1'b1; // R23

	// forward-reverse: which half of the duty range
	wire fr_rev = (duty_cmd > c_d); // R10

	// ramps of the forward and reverse halves
	wire [LVL_W-1:0] fwd_ramp = lerp(duty_cmd, low_clamp_duty, a_d, low_clamp_level, a_l);
	wire [LVL_W-1:0] rev_ramp = lerp(duty_cmd, e_d, high_clamp_duty, e_l, high_clamp_level);

	// forward half
	wire [LVL_W-1:0] fwd_lvl =
		(duty_cmd < low_turn_off_duty) ? low_turn_off_level : // R12
		(duty_cmd < low_clamp_duty)    ? low_clamp_level :    // R13
		(duty_cmd < a_d)               ? fwd_ramp :           // R14
		(duty_cmd <= b_d)              ? a_l :                // R15
		LVL_ZERO;                                             // R15

	// reverse half
	wire [LVL_W-1:0] rev_lvl =
		(duty_cmd <= d_d)               ? LVL_ZERO :            // R16
		(duty_cmd < e_d)                ? d_l :                 // R16
		(duty_cmd < high_clamp_duty)    ? rev_ramp :            // R17
		(duty_cmd > high_turn_off_duty) ? high_turn_off_level : // R19
		high_clamp_level;                                       // R17

	// forward-reverse start from zero
	wire fwd_go = from_zero ? (duty_cmd > low_turn_on_duty) : 1'b1;  // R11
	wire rev_go = from_zero ? (duty_cmd < high_turn_on_duty) : 1'b1; // R18
	// a running motor that crosses c must pass through zero first
	wire dir_flip = !from_zero && (ref_q.reverse != fr_rev);
	wire fr_go    = !dir_flip && (fr_rev ? rev_go : fwd_go);
	wire [LVL_W-1:0] fr_lvl = fr_rev ? rev_lvl : fwd_lvl; // R9

	// direct mode: duty scaled to full level range, with hysteresis
	wire [LVL_W-1:0] direct_lvl = {duty_cmd, {(LVL_W-DUTY_W){1'b0}}};
	wire hyst_hold = (duty_cmd > duty_hysteresis_width) &&
	                 (duty_dist(duty_cmd, hyst_base_q) < duty_hysteresis_width); // R21

	// next reference, chosen by profile
	always_comb begin
		ref_d       = ref_q;
		hyst_base_d = hyst_base_q;
		unique case (profile)
			PROF_STAIR: begin // R1
				ref_d.reverse = 1'b0;
				ref_d.level   = stair_go ? stair_lvl : LVL_ZERO;
			end
			PROF_FWDREV: begin // R9
				ref_d.reverse = fr_go ? fr_rev : ref_q.reverse;
				ref_d.level   = fr_go ? fr_lvl : LVL_ZERO;
			end
			PROF_DIRECT, PROF_LINEAR: begin
				ref_d.reverse = 1'b0;
				if (!hyst_hold) begin
					ref_d.level = direct_lvl; // R21
					hyst_base_d = duty_cmd;
				end
			end
		endcase
		// zero command overrides every threshold
		if (duty_cmd == DUTY_ZERO) begin
			ref_d.level = LVL_ZERO; // R20
			hyst_base_d = DUTY_ZERO;
		end
	end

	// off/run follows whether the next reference is zero
	assign state_d = (ref_d.level == LVL_ZERO) ? DSP_OFF : DSP_RUN; // R23

	// reference register, updated once per duty update
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_q       <= '0;
			state_q     <= DSP_OFF;
			valid_q     <= 1'b0;
			duty_seen_q <= DUTY_ZERO;
			hyst_base_q <= DUTY_ZERO;
		end else begin
			valid_q <= duty_valid; // R22
			if (duty_valid) begin
				ref_q       <= ref_d; // R22
				state_q     <= state_d;
				duty_seen_q <= duty_cmd;
				hyst_base_q <= hyst_base_d;
			end
		end
	end

	// outputs to the control loop
	assign speed_ref     = ref_q;
	assign speed_valid   = valid_q;
	assign motor_running = (state_q == DSP_RUN);

	// size and low address bits are accepted but not checked: word access only
	wire unused_ok = &{1'b0, hsize, haddr[1:0]};

endmodule

// >>> hdl/dsp_pkg.sv
// constants, register map and types for the duty-to-speed profile mapper
package dsp_pkg;

	// widths
	localparam int DUTY_W = 8;
	localparam int LVL_W  = 16;
	localparam int NREG   = 12;
	localparam int IDX_W  = 4;

	// register byte offsets
	localparam logic [7:0] OFS_PROFILE_CTRL = 8'h00;
	localparam logic [7:0] OFS_LOW_DUTY     = 8'h04;
	localparam logic [7:0] OFS_HIGH_DUTY    = 8'h08;
	localparam logic [7:0] OFS_POINT_DUTY   = 8'h0c;
	localparam logic [7:0] OFS_POINT_E_DUTY = 8'h10;
	localparam logic [7:0] OFS_LOW_LEVEL    = 8'h14;
	localparam logic [7:0] OFS_HIGH_LEVEL   = 8'h18;
	localparam logic [7:0] OFS_LEVEL_AB     = 8'h1c;
	localparam logic [7:0] OFS_LEVEL_CD     = 8'h20;
	localparam logic [7:0] OFS_LEVEL_E      = 8'h24;
	localparam logic [7:0] OFS_STATUS       = 8'h28;
	localparam logic [7:0] OFS_DUTY_SEEN    = 8'h2c;

	// word indices of the same registers
	localparam logic [IDX_W-1:0] IX_CTRL   = 4'h0;
	localparam logic [IDX_W-1:0] IX_LDUTY  = 4'h1;
	localparam logic [IDX_W-1:0] IX_HDUTY  = 4'h2;
	localparam logic [IDX_W-1:0] IX_PDUTY  = 4'h3;
	localparam logic [IDX_W-1:0] IX_EDUTY  = 4'h4;
	localparam logic [IDX_W-1:0] IX_LLVL   = 4'h5;
	localparam logic [IDX_W-1:0] IX_HLVL   = 4'h6;
	localparam logic [IDX_W-1:0] IX_ABLVL  = 4'h7;
	localparam logic [IDX_W-1:0] IX_CDLVL  = 4'h8;
	localparam logic [IDX_W-1:0] IX_ELVL   = 4'h9;
	localparam logic [IDX_W-1:0] IX_STATUS = 4'ha;
	localparam logic [IDX_W-1:0] IX_DSEEN  = 4'hb;

	// field positions
	localparam int F_PROF   = 0;
	localparam int F_HYST   = 8;
	localparam int F_BYTE0  = 0;
	localparam int F_BYTE1  = 8;
	localparam int F_BYTE2  = 16;
	localparam int F_BYTE3  = 24;
	localparam int F_HALF0  = 0;
	localparam int F_HALF1  = 16;
	localparam int F_REV    = 16;
	localparam int F_RUN    = 17;

	// writable bits of each word
	localparam logic [31:0] MASK_CTRL = 32'h0000_ff03;
	localparam logic [31:0] MASK_3B   = 32'h00ff_ffff;
	localparam logic [31:0] MASK_4B   = 32'hffff_ffff;
	localparam logic [31:0] MASK_1B   = 32'h0000_00ff;
	localparam logic [31:0] MASK_1H   = 32'h0000_ffff;
	localparam logic [31:0] MASK_NONE = 32'h0000_0000;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// profile select codes
	localparam logic [1:0] PROF_DIRECT = 2'b00;
	localparam logic [1:0] PROF_LINEAR = 2'b01;
	localparam logic [1:0] PROF_STAIR  = 2'b10;
	localparam logic [1:0] PROF_FWDREV = 2'b11;

	// ahb codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HRESP_OKAY    = 2'b00;

	localparam logic [DUTY_W-1:0] DUTY_ZERO = 8'h00;
	localparam logic [LVL_W-1:0]  LVL_ZERO  = 16'h0000;

	// speed reference as handed to the control loop
	typedef struct packed {
		logic             reverse;
		logic [LVL_W-1:0] level;
	} dsp_ref_t;

	typedef enum logic {DSP_OFF, DSP_RUN} dsp_state_t;

endpackage

// >>> verif/dsp_checker.sv
// port assertions for the duty-to-speed profile mapper
`timescale 1ns/1ps
module dsp_checker
	import dsp_pkg::*;
(
	// clock and reset
	input wire logic              hclk,
	input wire logic              hresetn,
	// bus side
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic              hready,
	input wire logic              hreadyout,
	input wire logic [1:0]        hresp,
	input wire logic [31:0]       hrdata,
	// duty in, speed out
	input wire logic [DUTY_W-1:0] duty_cmd,
	input wire logic              duty_valid,
	input wire dsp_ref_t          speed_ref,
	input wire logic              speed_valid,
	input wire logic              motor_running
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// a read address phase is the only event allowed to reload hrdata
	wire rd_take = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;

	valid_follow_a: assert property (duty_valid |=> speed_valid)
		else $error("no speed_valid after a duty update");
	valid_pulse_a: assert property (!duty_valid |=> !speed_valid)
		else $error("speed_valid without a duty update");
	ref_hold_a: assert property (!duty_valid |=> $stable(speed_ref))
		else $error("speed reference moved without a duty update");
	running_level_a: assert property (motor_running == (speed_ref.level != LVL_ZERO))
		else $error("running flag disagrees with the level");
	zero_stop_a: assert property (duty_valid && duty_cmd == DUTY_ZERO |=> !motor_running)
		else $error("zero duty left the motor running");
	off_start_a: assert property (!motor_running && !duty_valid |=> !motor_running)
		else $error("motor started without a duty update");
	bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
		else $error("slave stalled or answered with an error");
	rdata_hold_a: assert property (!rd_take |=> $stable(hrdata))
		else $error("read data changed outside a read");
	unmapped_zero_a: assert property (rd_take && haddr >= 32'h30 |=> hrdata == 32'h0)
		else $error("unmapped read returned nonzero data");

	cover property (duty_valid && duty_cmd == DUTY_ZERO);
	cover property ($rose(motor_running));
	cover property ($rose(speed_ref.reverse));
endmodule

bind dsp_mapper dsp_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .duty_cmd(duty_cmd),
	.duty_valid(duty_valid), .speed_ref(speed_ref), .speed_valid(speed_valid),
	.motor_running(motor_running));

// >>> verif/dsp_partner.sv
// duty command source and speed loop capture
`timescale 1ns/1ps
module dsp_partner
	import dsp_pkg::*;
(
	// clock
	input  wire logic              hclk,
	// toward the mapper
	output logic [DUTY_W-1:0]      duty_cmd,
	output logic                   duty_valid,
	// from the mapper
	input  wire dsp_ref_t          speed_ref,
	input  wire logic              speed_valid
);
	initial begin
		duty_cmd   = DUTY_ZERO;
		duty_valid = 1'b0;
	end
	// one update; the command is scrambled after so stale data is never reused
	task automatic send(input logic [DUTY_W-1:0] d, output dsp_ref_t r, output logic ok);
		int i;
		ok = 1'b0;
		@(posedge hclk);
		duty_cmd   <= d;
		duty_valid <= 1'b1;
		@(posedge hclk);
		duty_valid <= 1'b0;
		duty_cmd   <= ~d;
		for (i = 0; i < 8 && ok !== 1'b1; i++) begin
			#1;
			if (speed_valid === 1'b1) begin
				r  = speed_ref;
				ok = 1'b1;
			end else begin
				@(posedge hclk);
			end
		end
	endtask
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the duty-to-speed profile mapper
`timescale 1ns/1ps
module tb_top
	import dsp_pkg::*;
;
	logic              hclk = 1'b0;
	logic              hresetn = 1'b0;
	logic              hsel = 1'b0;
	logic [31:0]       haddr = 32'h0;
	logic [1:0]        htrans = 2'b00;
	logic              hwrite = 1'b0;
	logic [2:0]        hsize = 3'b010;
	logic [31:0]       hwdata = 32'h0;
	logic              hready;
	logic [1:0]        hresp;
	logic [31:0]       hrdata;
	logic [DUTY_W-1:0] duty_cmd;
	logic              duty_valid;
	dsp_ref_t          speed_ref;
	logic              speed_valid;
	logic              motor_running;
	int                n_mismatch = 0;
	int                n_compared = 0;

	always #5 hclk = ~hclk;

	dsp_mapper dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.duty_cmd(duty_cmd), .duty_valid(duty_valid), .speed_ref(speed_ref),
		.speed_valid(speed_valid), .motor_running(motor_running));
	dsp_partner u_src (.hclk(hclk), .duty_cmd(duty_cmd), .duty_valid(duty_valid),
		.speed_ref(speed_ref), .speed_valid(speed_valid));

	task automatic finish_test();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait for hready; a hang ends the run
	task automatic wait_rdy();
		int i;
		for (i = 0; i < 32; i++) begin
			@(posedge hclk);
			if (hready === 1'b1) break;
		end
		if (i == 32) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask
	// one duty update, judged on level, running flag and direction
	task automatic step(input logic [DUTY_W-1:0] d, input logic [LVL_W-1:0] lvl,
		input logic rev);
		dsp_ref_t r;
		logic     ok;
		u_src.send(d, r, ok);
		if (ok !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
		chk({16'h0, r.level}, {16'h0, lvl});
		chk({31'h0, motor_running}, {31'h0, lvl != LVL_ZERO});
		if (lvl != LVL_ZERO) begin
			chk({31'h0, r.reverse}, {31'h0, rev});
		end
	endtask
	// thresholds: on1 10 off1 08 clamp1 20, A-E 40..b0, clamp2 c0 on2 e0 off2 f0
	task automatic cfg(input logic [31:0] ctrl);
		wr(OFS_LOW_DUTY, 32'h0020_0810);
		wr(OFS_HIGH_DUTY, 32'h00f0_e0c0);
		wr(OFS_POINT_DUTY, 32'ha080_6040);
		wr(OFS_POINT_E_DUTY, 32'h0000_00b0);
		wr(OFS_LOW_LEVEL, 32'h0050_0100);
		wr(OFS_HIGH_LEVEL, 32'h0080_0900);
		wr(OFS_LEVEL_AB, 32'h0300_0200);
		wr(OFS_LEVEL_CD, 32'h0500_0400);
		wr(OFS_LEVEL_E, 32'h0000_0600);
		wr(OFS_PROFILE_CTRL, ctrl);
	endtask
	task automatic t_regs();
		rd_chk(OFS_PROFILE_CTRL, RESET_WORD);
		rd_chk(OFS_LEVEL_E, RESET_WORD);
		wr(OFS_PROFILE_CTRL, 32'hffff_ffff);
		rd_chk(OFS_PROFILE_CTRL, MASK_CTRL);
		wr(OFS_STATUS, 32'hffff_ffff);
		rd_chk(OFS_STATUS, RESET_WORD);
		rd_chk(8'h30, RESET_WORD);
	endtask
	task automatic t_stair();
		cfg({30'h0, PROF_STAIR});
		step(8'h00, 16'h0000, 1'b0);
		step(8'h0c, 16'h0000, 1'b0);
		step(8'h18, 16'h0100, 1'b0);
		step(8'h05, 16'h0050, 1'b0);
		step(8'h20, 16'h0200, 1'b0);
		step(8'h40, 16'h0300, 1'b0);
		step(8'h60, 16'h0400, 1'b0);
		step(8'h80, 16'h0500, 1'b0);
		step(8'ha0, 16'h0600, 1'b0);
		step(8'hb0, 16'h0900, 1'b0);
		step(8'hf0, 16'h0900, 1'b0);
		step(8'hf5, 16'h0080, 1'b0);
		step(8'h00, 16'h0000, 1'b0);
		step(8'he8, 16'h0000, 1'b0);
		step(8'hd0, 16'h0900, 1'b0);
		rd_chk(OFS_STATUS, 32'h0002_0900);
		rd_chk(OFS_DUTY_SEEN, 32'h0000_00d0);
	endtask
	task automatic t_fwdrev();
		cfg({30'h0, PROF_FWDREV});
		step(8'h00, 16'h0000, 1'b0);
		step(8'h0c, 16'h0000, 1'b0);
		step(8'h18, 16'h0100, 1'b0);
		step(8'h05, 16'h0050, 1'b0);
		step(8'h10, 16'h0100, 1'b0);
		step(8'h30, 16'h0180, 1'b0);
		step(8'h50, 16'h0200, 1'b0);
		step(8'h70, 16'h0000, 1'b0);
		step(8'h90, 16'h0000, 1'b1);
		step(8'ha8, 16'h0500, 1'b1);
		step(8'hb8, 16'h0780, 1'b1);
		step(8'hd0, 16'h0900, 1'b1);
		step(8'hf5, 16'h0080, 1'b1);
		step(8'h00, 16'h0000, 1'b1);
		step(8'he8, 16'h0000, 1'b1);
		step(8'hd0, 16'h0900, 1'b1);
	endtask
	task automatic t_direct();
		cfg(32'h0000_1000);
		step(8'h00, 16'h0000, 1'b0);
		step(8'h40, 16'h4000, 1'b0);
		step(8'h48, 16'h4000, 1'b0);
		step(8'h58, 16'h5800, 1'b0);
		step(8'h08, 16'h0800, 1'b0);
		// the linear code runs as direct; zero width never holds
		wr(OFS_PROFILE_CTRL, {30'h0, PROF_LINEAR});
		step(8'h30, 16'h3000, 1'b0);
	endtask
	// mid-run reset clears the reference and the configuration
	task automatic t_reset();
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		chk({15'h0, speed_ref}, 32'h0);
		chk({31'h0, motor_running}, 32'h0);
		hresetn <= 1'b1;
		rd_chk(OFS_PROFILE_CTRL, RESET_WORD);
		rd_chk(OFS_STATUS, RESET_WORD);
	endtask

	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_stair();
		t_fwdrev();
		t_direct();
		t_reset();
		finish_test();
	end
endmodule
